// file: hwo_pkg.sv
// Shared constants of the hit window output logic: register map, field
// positions, widths and values after reset.
// Assumes a single 40 MHz clock domain and a 32-bit word register port.
package hwo_pkg;
	localparam int N_WIN      = 16;           // Analysis windows per task
	localparam int N_OUT      = 4;            // Switching outputs per task
	localparam int N_COL      = 4;            // AND columns per output
	localparam int HIT_W      = 9;            // Hit count width, 0 to 511
	localparam int SUM_W      = 13;           // Room for sixteen full windows
	localparam int TASK_W     = 4;            // Tasks 0 to 15
	localparam int SEL_W      = 3;            // Task select inputs
	localparam int ADDR_W     = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [1:0] WIN_PAGE     = 2'h1;  // 0x40..0x7c, one word per window
	localparam logic [2:0] OW_CTRL      = 3'h0;  // Output page 0x80 + 0x20*n, word 0
	localparam logic [2:0] OW_HITS      = 3'h1;  // Word 1, sum thresholds
	localparam logic [2:0] OW_COL0      = 3'h2;  // Words 2 to 5, one per column

	// Control register fields
	localparam int CTRL_EXT_SEL = 0;
	localparam int CTRL_SINGLE  = 1;
	localparam int CTRL_REQ     = 2;          // Write 1: request one measurement
	localparam int CTRL_COMMIT  = 3;          // Write 1: store all task sets
	localparam int CTRL_FACTORY = 4;          // Write 1: restore defaults
	localparam int CTRL_TASK_LO = 8;

	// Output control fields
	localparam int OC_ACTIVE  = 0;
	localparam int OC_NEGATE  = 1;
	localparam int OC_SUM     = 2;
	localparam int OC_DEPTH_LO = 8;
	localparam int HI_OFF_LO   = 16;         // Off threshold field, on sits at bit 0
	localparam int COL_MINUS_LO = 16;        // Minus marks, plus marks at bit 0

	// Values after reset and after a factory restore
	localparam logic [8:0] RST_HITS_ON  = 9'h00a;
	localparam logic [8:0] RST_HITS_OFF = 9'h006;
	localparam logic [7:0] RST_DEPTH    = 8'h01;
	localparam logic [3:0] RST_TASK     = 4'h0;
endpackage

// file: hwo_output.sv
// One switching output: column logic, sum mode with hysteresis, negation,
// debounce over successive evaluations.
// Assumes window states and hit counts are stable while i_eval is high.
`timescale 1ns/1ps
module hwo_output #(
	parameter int N_WIN = hwo_pkg::N_WIN,
	parameter int N_COL = hwo_pkg::N_COL,
	parameter int HIT_W = hwo_pkg::HIT_W,
	parameter int SUM_W = hwo_pkg::SUM_W
) (
	// Clock and reset
	input  wire logic                     i_clock,
	input  wire logic                     i_rst,
	// Evaluation pacing
	input  wire logic                     i_eval,
	input  wire logic                     i_single,
	// Window data
	input  wire logic [N_WIN-1:0]         i_win_state,
	input  wire logic [N_WIN*HIT_W-1:0]   i_hits,
	// Settings of this output
	input  wire logic [N_COL*N_WIN-1:0]   i_plus,
	input  wire logic [N_COL*N_WIN-1:0]   i_minus,
	input  wire logic                     i_sum_mode,
	input  wire logic                     i_negate,
	input  wire logic                     i_active,
	input  wire logic [7:0]               i_depth,
	input  wire logic [HIT_W-1:0]         i_hits_on,
	input  wire logic [HIT_W-1:0]         i_hits_off,
	// Result
	output logic                          o_switch
);
	logic [N_COL-1:0] col_res;
	logic [SUM_W-1:0] hit_sum;
	logic             raw_reg;
	logic             raw_next;
	logic             eval_res;
	logic             state_reg;
	logic [7:0]       cnt_reg;
	logic [7:0]       cnt_inc;
	logic             flip;

	// Per column: blank entries pass, plus takes the state, minus its inverse
	always_comb begin
		for (int c = 0; c < N_COL; c++) begin
			col_res[c] = |(i_plus[c*N_WIN +: N_WIN] | i_minus[c*N_WIN +: N_WIN]) &
				&(~(i_plus[c*N_WIN +: N_WIN] | i_minus[c*N_WIN +: N_WIN]) |
				(i_plus[c*N_WIN +: N_WIN] & i_win_state) |
				(i_minus[c*N_WIN +: N_WIN] & ~i_win_state));
		end
	end

	// Sum only plus windows of the first column; minus, blank and other columns stay out
	always_comb begin
		hit_sum = '0;
		for (int w = 0; w < N_WIN; w++) begin
			if (i_plus[w] && !i_minus[w])
				hit_sum = hit_sum + SUM_W'(i_hits[w*HIT_W +: HIT_W]);
		end
	end

	// Between the thresholds the last result stands, giving hysteresis
	assign raw_next = !i_sum_mode ? |col_res :
		(hit_sum >= SUM_W'(i_hits_on))  ? 1'b1 :
		(hit_sum <= SUM_W'(i_hits_off)) ? 1'b0 : raw_reg;
	assign eval_res = raw_next ^ i_negate;
	assign cnt_inc  = cnt_reg + 8'h01;
	// Depth 0 behaves as 1; a single shot shows its one analysis directly
	assign flip     = (eval_res != state_reg) && (i_single || cnt_inc >= i_depth);

	// Debounce: count successive differing results, reset on an agreeing one
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			raw_reg   <= 1'b0;
			state_reg <= 1'b0;
			cnt_reg   <= 8'h00;
			o_switch  <= 1'b0;
		end else begin
			if (i_eval) begin
				raw_reg   <= raw_next;
				state_reg <= flip ? eval_res : state_reg;
				cnt_reg   <= (flip || eval_res == state_reg) ? 8'h00 : cnt_inc;
			end
			o_switch <= i_active & (i_eval && flip ? eval_res : state_reg);
		end
	end
endmodule

// file: hwo_core.sv
// Hit window output logic: register port, window hysteresis, task selection,
// single shot pacing and four switching outputs.
// Assumes hit counts arrive with a one-cycle evaluation strobe per trigger or
// per profile, and that storage of task sets is done by the unit outside.
// Limitation: only the active task's settings live here; the unit outside
// reloads them whenever o_task moves and keeps all sets on o_commit.
//
// How it works
// - Sum mode adds plus windows of column one
// - Sum skips minus, blank, and columns two-four
// - Sum at or above upper threshold: active
// - Sum at or below lower threshold: inactive
// - Between thresholds the previous state holds
// - Single shot: one analysis per request, held
// - External selection picks tasks 0-7 from inputs
// - Fieldbus may select any task 0-15
// - External selection ignores configured task number
// - Per window hit count with hysteresis limits
// - Columns AND their windows, minus ones inverted
// - Four column results ORed per output
// - Optional negation of each ORed result
// - Sixteen windows and four outputs per task
// - Commit stores task sets; factory restores defaults
// - Toggle after depth successive equal results
// - Plus as-is, minus inverted, blank ignored
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
module hwo_core #(
	parameter int N_WIN = hwo_pkg::N_WIN,
	parameter int N_OUT = hwo_pkg::N_OUT,
	parameter int N_COL = hwo_pkg::N_COL,
	parameter int HIT_W = hwo_pkg::HIT_W
) (
	// Clock and reset
	input  wire logic                              i_clock,
	input  wire logic                              i_rst,
	// Register port
	input  wire logic [hwo_pkg::ADDR_W-1:0]        i_addr,
	input  wire logic [31:0]                       i_wdata,
	input  wire logic                              i_wr,
	input  wire logic                              i_rd,
	output logic      [31:0]                       o_rdata,
	// Profile data
	input  wire logic                              i_eval,
	input  wire logic [N_WIN*HIT_W-1:0]            i_hits,
	// Task selection
	input  wire logic [hwo_pkg::SEL_W-1:0]         i_task_select_inputs,
	input  wire logic [hwo_pkg::TASK_W-1:0]        i_bus_task,
	input  wire logic                              i_bus_task_valid,
	// Results
	output logic      [N_OUT-1:0]                  o_switch_outputs,
	output logic      [hwo_pkg::TASK_W-1:0]        o_task,
	output logic                                   o_commit,
	output logic                                   o_factory
);
	// Values after reset cut to this instance's hit width
	localparam logic [HIT_W-1:0] RST_ON  = HIT_W'(hwo_pkg::RST_HITS_ON);
	localparam logic [HIT_W-1:0] RST_OFF = HIT_W'(hwo_pkg::RST_HITS_OFF);

	// Settings held in flip-flops, indexed per window and per output
	logic [HIT_W-1:0]       win_on_reg   [N_WIN];
	logic [HIT_W-1:0]       win_off_reg  [N_WIN];
	logic [N_OUT-1:0]       oc_active_reg;
	logic [N_OUT-1:0]       oc_negate_reg;
	logic [N_OUT-1:0]       oc_sum_reg;
	logic [7:0]             oc_depth_reg [N_OUT];
	logic [HIT_W-1:0]       hits_on_reg  [N_OUT];
	logic [HIT_W-1:0]       hits_off_reg [N_OUT];
	logic [N_COL*N_WIN-1:0] plus_reg     [N_OUT];
	logic [N_COL*N_WIN-1:0] minus_reg    [N_OUT];
	logic                   ext_sel_reg;
	logic                   single_reg;
	logic                   req_reg;
	logic [3:0]             cfg_task_reg;
	logic [N_WIN-1:0]       win_state_reg;
	logic                   eval_reg;
	logic                   single_eval_reg;
	logic [31:0]            rdata_next;
	logic [3:0]             task_next;
	logic [N_OUT-1:0]       sw;
	logic [N_WIN-1:0]       win_up;
	logic [N_WIN-1:0]       win_down;
	logic [N_COL*N_WIN-1:0] plus_eff     [N_OUT];
	logic [3:0]             ext_task;

	// Register decode; unaligned words are holes, so writes there are dropped too
	wire        aligned   = i_addr[1:0] == 2'h0;
	wire        wr_ctrl   = i_wr && i_addr == hwo_pkg::OFS_CTRL;
	wire        sel_win   = aligned && i_addr[7:6] == hwo_pkg::WIN_PAGE;
	wire        sel_out   = aligned && i_addr[7];
	wire        wr_win    = i_wr && sel_win;
	wire        wr_out    = i_wr && sel_out;
	wire [3:0]  win_idx   = i_addr[5:2];
	wire [1:0]  out_idx   = i_addr[6:5];
	wire [2:0]  out_word  = i_addr[4:2];
	wire        factory   = wr_ctrl && i_wdata[hwo_pkg::CTRL_FACTORY];
	wire        commit    = wr_ctrl && i_wdata[hwo_pkg::CTRL_COMMIT];
	wire        req_set   = wr_ctrl && i_wdata[hwo_pkg::CTRL_REQ];
	wire        eval_go   = i_eval && (!single_reg || req_reg);

	// Whether a word index is a column register, and which column it holds
	function automatic logic col_hit(input logic [2:0] word);
		col_hit = word >= hwo_pkg::OW_COL0 && word < hwo_pkg::OW_COL0 + 3'(N_COL);
	endfunction

	function automatic logic [1:0] col_of(input logic [2:0] word);
		col_of = 2'(word - hwo_pkg::OW_COL0);
	endfunction

	// Hit count of one window out of the packed profile word
	function automatic logic [HIT_W-1:0] win_hits(input logic [N_WIN*HIT_W-1:0] h, input int w);
		win_hits = h[w*HIT_W +: HIT_W];
	endfunction

	// The fieldbus number wins over the select inputs while it is marked valid
	assign ext_task  = i_bus_task_valid ? i_bus_task :
		{1'b0, i_task_select_inputs};
	// Inputs or fieldbus own the task while external selection is on
	assign task_next = ext_sel_reg ? ext_task : cfg_task_reg;

	// Per window limit compares; the on limit is tried first
	for (genvar w = 0; w < N_WIN; w++) begin : g_win
		assign win_up[w]   = eval_go && win_hits(i_hits, w) >= win_on_reg[w];
		assign win_down[w] = eval_go && win_hits(i_hits, w) <= win_off_reg[w];
	end

	// Read multiplexer; unmapped words read zero
	// The mux looks at the address alone; the strobe gates it one stage later
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (i_addr == hwo_pkg::OFS_CTRL) begin
			rdata_next[hwo_pkg::CTRL_EXT_SEL] = ext_sel_reg;
			rdata_next[hwo_pkg::CTRL_SINGLE]  = single_reg;
			rdata_next[hwo_pkg::CTRL_REQ]     = req_reg;
			rdata_next[hwo_pkg::CTRL_TASK_LO +: 4] = cfg_task_reg;
		end else if (i_addr == hwo_pkg::OFS_STATUS) begin
			// Outputs, active task and window states side by side
			rdata_next[N_OUT-1:0]  = o_switch_outputs;
			rdata_next[11:8]       = o_task;
			rdata_next[31:16]      = win_state_reg;
		end else if (sel_win && i_addr[1:0] == 2'h0) begin
			rdata_next[HIT_W-1:0]  = win_on_reg[win_idx];
			rdata_next[hwo_pkg::HI_OFF_LO +: HIT_W] = win_off_reg[win_idx];
		end else if (sel_out && i_addr[1:0] == 2'h0) begin
			if (out_word == hwo_pkg::OW_CTRL) begin
				rdata_next[hwo_pkg::OC_ACTIVE] = oc_active_reg[out_idx];
				rdata_next[hwo_pkg::OC_NEGATE] = oc_negate_reg[out_idx];
				rdata_next[hwo_pkg::OC_SUM]    = oc_sum_reg[out_idx];
				rdata_next[hwo_pkg::OC_DEPTH_LO +: 8] = oc_depth_reg[out_idx];
			end else if (out_word == hwo_pkg::OW_HITS) begin
				rdata_next[HIT_W-1:0] = hits_on_reg[out_idx];
				rdata_next[hwo_pkg::HI_OFF_LO +: HIT_W] = hits_off_reg[out_idx];
			end else if (col_hit(out_word)) begin
				rdata_next[N_WIN-1:0] = plus_reg[out_idx][col_of(out_word)*N_WIN +: N_WIN];
				rdata_next[hwo_pkg::COL_MINUS_LO +: N_WIN] =
					minus_reg[out_idx][col_of(out_word)*N_WIN +: N_WIN];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	// Idle zero lets several blocks share one wired-or read bus
	always_ff @(posedge i_clock) begin
		if (i_rst)
			o_rdata <= 32'h0000_0000;
		else
			o_rdata <= i_rd ? rdata_next : 32'h0000_0000;
	end

	// Global control; the request waits for the next evaluation strobe
	// A control write rewrites every mode bit and the configured task at once
	always_ff @(posedge i_clock) begin
		if (i_rst || factory) begin
			ext_sel_reg  <= 1'b0;
			single_reg   <= 1'b0;
			req_reg      <= 1'b0;
			cfg_task_reg <= hwo_pkg::RST_TASK;
		end else begin
			if (wr_ctrl) begin
				ext_sel_reg  <= i_wdata[hwo_pkg::CTRL_EXT_SEL];
				single_reg   <= i_wdata[hwo_pkg::CTRL_SINGLE];
				cfg_task_reg <= i_wdata[hwo_pkg::CTRL_TASK_LO +: 4];
			end
			// A new request beside the consuming strobe is kept: set wins over clear
			req_reg <= req_set || (req_reg && !eval_go);
		end
	end

	// Pulses to the storage unit and the pacing of the outputs
	// Store and restore only pulse here; the slow storage work is done outside
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_commit        <= 1'b0;
			o_factory       <= 1'b0;
			o_task          <= hwo_pkg::RST_TASK;
			eval_reg        <= 1'b0;
			single_eval_reg <= 1'b0;
		end else begin
			o_commit        <= commit;
			o_factory       <= factory;
			o_task          <= task_next;
			eval_reg        <= eval_go;
			single_eval_reg <= single_reg;
		end
	end

	// Window settings and per window state with hysteresis
	// A factory write also clears the states, so outputs restart from quiet
	always_ff @(posedge i_clock) begin
		if (i_rst || factory) begin
			for (int w = 0; w < N_WIN; w++) begin
				win_on_reg[w]  <= RST_ON;
				win_off_reg[w] <= RST_OFF;
			end
			win_state_reg <= '0;
		end else begin
			if (wr_win) begin
				win_on_reg[win_idx]  <= i_wdata[HIT_W-1:0];
				win_off_reg[win_idx] <= i_wdata[hwo_pkg::HI_OFF_LO +: HIT_W];
			end
			for (int w = 0; w < N_WIN; w++) begin
				if (win_up[w])
					win_state_reg[w] <= 1'b1;
				else if (win_down[w])
					win_state_reg[w] <= 1'b0;
			end
		end
	end

	// Output settings; writes to the unused words of a page are dropped
	// Depth, thresholds and column marks all reload on a factory write
	always_ff @(posedge i_clock) begin
		if (i_rst || factory) begin
			for (int o = 0; o < N_OUT; o++) begin
				oc_depth_reg[o] <= hwo_pkg::RST_DEPTH;
				hits_on_reg[o]  <= RST_ON;
				hits_off_reg[o] <= RST_OFF;
				plus_reg[o]     <= '0;
				minus_reg[o]    <= '0;
			end
			oc_active_reg <= '0;
			oc_negate_reg <= '0;
			oc_sum_reg    <= '0;
		end else if (wr_out) begin
			if (out_word == hwo_pkg::OW_CTRL) begin
				oc_active_reg[out_idx] <= i_wdata[hwo_pkg::OC_ACTIVE];
				oc_negate_reg[out_idx] <= i_wdata[hwo_pkg::OC_NEGATE];
				oc_sum_reg[out_idx]    <= i_wdata[hwo_pkg::OC_SUM];
				oc_depth_reg[out_idx]  <= i_wdata[hwo_pkg::OC_DEPTH_LO +: 8];
			end else if (out_word == hwo_pkg::OW_HITS) begin
				hits_on_reg[out_idx]  <= i_wdata[HIT_W-1:0];
				hits_off_reg[out_idx] <= i_wdata[hwo_pkg::HI_OFF_LO +: HIT_W];
			end else if (col_hit(out_word)) begin
				// A window marked both plus and minus counts as minus
				plus_reg[out_idx][col_of(out_word)*N_WIN +: N_WIN]  <= i_wdata[N_WIN-1:0];
				minus_reg[out_idx][col_of(out_word)*N_WIN +: N_WIN] <=
					i_wdata[hwo_pkg::COL_MINUS_LO +: N_WIN];
			end
		end
	end

	// Hits are copied in the strobe cycle, so they need not stay until eval_reg
	// The sum reads this copy, so it sees the same profile as the window states
	logic [N_WIN*HIT_W-1:0] hits_reg;
	always_ff @(posedge i_clock) begin
		if (i_rst)
			hits_reg <= '0;
		else if (eval_go)
			hits_reg <= i_hits;
	end

	// Four switching outputs, each debounced on its own
	// Minus wins over plus, so each window enters a column one way only
	for (genvar o = 0; o < N_OUT; o++) begin : g_out
		assign plus_eff[o] = plus_reg[o] & ~minus_reg[o];
		hwo_output #(
			.N_WIN (N_WIN),
			.N_COL (N_COL),
			.HIT_W (HIT_W)
		) u_out (
			.i_clock     (i_clock),
			.i_rst       (i_rst || factory),
			.i_eval      (eval_reg),
			.i_single    (single_eval_reg),
			.i_win_state (win_state_reg),
			.i_hits      (hits_reg),
			.i_plus      (plus_eff[o]),
			.i_minus     (minus_reg[o]),
			.i_sum_mode  (oc_sum_reg[o]),
			.i_negate    (oc_negate_reg[o]),
			.i_active    (oc_active_reg[o]),
			.i_depth     (oc_depth_reg[o]),
			.i_hits_on   (hits_on_reg[o]),
			.i_hits_off  (hits_off_reg[o]),
			.o_switch    (sw[o])
		);
	end

	assign o_switch_outputs = sw; // Each bit is the flop inside its output module
endmodule

// file: hwo_core_checker.sv
// Port checker of the hit window output logic.
// Assumes it is bound into hwo_core and sees only that module's ports.
`timescale 1ns/1ps
module hwo_core_checker (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [31:0] o_rdata,
	// Pacing and selection
	input  wire logic        i_eval,
	input  wire logic [2:0]  i_task_select_inputs,
	input  wire logic [3:0]  i_bus_task,
	input  wire logic        i_bus_task_valid,
	// Results
	input  wire logic [3:0]  o_switch_outputs,
	input  wire logic [3:0]  o_task,
	input  wire logic        o_commit,
	input  wire logic        o_factory
);
	logic       ctrl_wr;
	logic       ext_reg;
	logic [3:0] task_reg;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Control word writes as seen on the port
	assign ctrl_wr = i_wr && (i_addr == hwo_pkg::OFS_CTRL);
	// Shadow of the selection settings; a factory restore clears them
	always_ff @(posedge i_clock) begin
		if (i_rst || (ctrl_wr && i_wdata[hwo_pkg::CTRL_FACTORY])) begin
			ext_reg  <= 1'b0;
			task_reg <= hwo_pkg::RST_TASK;
		end else if (ctrl_wr) begin
			ext_reg  <= i_wdata[hwo_pkg::CTRL_EXT_SEL];
			task_reg <= i_wdata[hwo_pkg::CTRL_TASK_LO +: 4];
		end
	end
	property p_cfg_task;
		!ext_reg |=> o_task == $past(task_reg);
	endproperty
	a_cfg_task: assert property (p_cfg_task) else $error("configured task not followed");
	property p_ext_inputs;
		ext_reg && !i_bus_task_valid |=> o_task == {1'b0, $past(i_task_select_inputs)};
	endproperty
	a_ext_inputs: assert property (p_ext_inputs) else $error("select inputs not followed");
	property p_ext_bus;
		ext_reg && i_bus_task_valid |=> o_task == $past(i_bus_task);
	endproperty
	a_ext_bus: assert property (p_ext_bus) else $error("fieldbus task not followed");
	// Outputs move only two cycles after a trigger or one or two cycles after a write
	property p_out_cause;
		$changed(o_switch_outputs) |-> $past(i_eval, 2) || $past(i_wr) || $past(i_wr, 2);
	endproperty
	a_out_cause: assert property (p_out_cause) else $error("outputs moved without a trigger");
	property p_status;
		i_rd && i_addr == hwo_pkg::OFS_STATUS |=> o_rdata[11:0] == {$past(o_task), 4'h0, $past(o_switch_outputs)};
	endproperty
	a_status: assert property (p_status) else $error("status word wrong");
	property p_commit;
		ctrl_wr && i_wdata[hwo_pkg::CTRL_COMMIT] |=> o_commit ##1 !o_commit;
	endproperty
	a_commit: assert property (p_commit) else $error("store pulse wrong");
	property p_factory;
		o_factory |-> $past(ctrl_wr) && $past(i_wdata[hwo_pkg::CTRL_FACTORY]);
	endproperty
	a_factory: assert property (p_factory) else $error("restore pulse without cause");
	property p_factory_clear;
		ctrl_wr && i_wdata[hwo_pkg::CTRL_FACTORY] |=> o_switch_outputs == 4'h0;
	endproperty
	a_factory_clear: assert property (p_factory_clear) else $error("outputs kept after restore");
	// Read data stand only in the cycle after the strobe
	property p_rd_idle;
		!i_rd |=> o_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unaligned;
		i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == 32'h0;
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("unaligned read not zero");
	c_eval: cover property (i_eval ##2 $changed(o_switch_outputs));
	c_bus: cover property (ext_reg && i_bus_task_valid);
	c_factory: cover property (o_factory);
endmodule
bind hwo_core hwo_core_checker u_hwo_core_checker (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_eval(i_eval),
	.i_task_select_inputs(i_task_select_inputs), .i_bus_task(i_bus_task), .i_bus_task_valid(i_bus_task_valid),
	.o_switch_outputs(o_switch_outputs), .o_task(o_task), .o_commit(o_commit), .o_factory(o_factory));

// file: hwo_proc_model.sv
// Process control model: triggers with hit counts, task select lines.
// Assumes the bench calls its tasks from processes paced by i_clock.
`timescale 1ns/1ps
module hwo_proc_model (
	// Clock
	input  wire logic         i_clock,
	// Towards the sensor logic
	output logic              o_eval,
	output logic [143:0]      o_hits,
	output logic [2:0]        o_task_select_inputs,
	output logic [3:0]        o_bus_task,
	output logic              o_bus_task_valid
);
	logic [8:0] hs [16];      // Hit counts staged for the next trigger
	// Quiet lines until the bench asks for something
	initial begin
		o_eval = 1'b0;
		o_hits = '0;
		o_task_select_inputs = 3'h0;
		o_bus_task = 4'h0;
		o_bus_task_valid = 1'b0;
		for (int k = 0; k < 16; k++)
			hs[k] = 9'h000;
	end
	// One strobe per trigger; counts stay put so the sampled cycle is safe
	task automatic trig();
		logic [143:0] v;
		for (int k = 0; k < 16; k++)
			v[9*k +: 9] = hs[k];
		@(posedge i_clock);
		o_eval <= 1'b1;
		o_hits <= v;
		@(posedge i_clock);
		o_eval <= 1'b0;
		repeat (2) @(posedge i_clock);
		#1;
	endtask
	// Select levels; bit 0 is the first input, fieldbus wins when valid
	task automatic sel(input logic [2:0] s, input logic [3:0] b, input logic v);
		@(posedge i_clock);
		o_task_select_inputs <= s;
		o_bus_task <= b;
		o_bus_task_valid <= v;
		repeat (2) @(posedge i_clock);
		#1;
	endtask
endmodule

// file: tb_top.sv
// Self-checking bench of the hit window output logic.
// Assumes hwo_core at its default sizes and the process control model.
`timescale 1ns/1ps
module tb_top;
	logic         i_clock;
	logic         i_rst;
	logic [7:0]   i_addr;
	logic [31:0]  i_wdata;
	logic         i_wr;
	logic         i_rd;
	logic [31:0]  o_rdata;
	logic         i_eval;
	logic [143:0] i_hits;
	logic [2:0]   i_task_select_inputs;
	logic [3:0]   i_bus_task;
	logic         i_bus_task_valid;
	logic [3:0]   o_switch_outputs;
	logic [3:0]   o_task;
	logic         o_commit;
	logic         o_factory;
	int           n_mismatch;
	int           checks;
	hwo_core u_hwo_core (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_eval(i_eval), .i_hits(i_hits),
		.i_task_select_inputs(i_task_select_inputs), .i_bus_task(i_bus_task), .i_bus_task_valid(i_bus_task_valid),
		.o_switch_outputs(o_switch_outputs), .o_task(o_task), .o_commit(o_commit), .o_factory(o_factory));
	hwo_proc_model u_hwo_proc_model (.i_clock(i_clock), .o_eval(i_eval), .o_hits(i_hits),
		.o_task_select_inputs(i_task_select_inputs), .o_bus_task(i_bus_task), .o_bus_task_valid(i_bus_task_valid));
	// 40 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One-cycle write strobe; a gap cycle keeps strobes from being set twice per edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	// Read data are looked at only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk($sformatf("rdata %h", a), o_rdata, exp);
	endtask
	function automatic logic [7:0] oa(input int n, input int w);
		return 8'h80 + 8'(32 * n + 4 * w);
	endfunction
	task automatic go(input logic [3:0] e);
		u_hwo_proc_model.trig();
		chk("outputs", {28'h0, o_switch_outputs}, {28'h0, e});
	endtask
	task automatic tsel(input logic [2:0] s, input logic [3:0] b, input logic v, input logic [3:0] e);
		u_hwo_proc_model.sel(s, b, v);
		chk("task", {28'h0, o_task}, {28'h0, e});
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog, about a hundred times the expected run
	initial begin
		repeat (20000) @(posedge i_clock);
		n_mismatch++;
		test_done();
	end
	initial begin
		n_mismatch = 0;
		checks = 0;
		i_rst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		// Values after reset; holes and unaligned places read zero
		for (int w = 0; w < 16; w++)
			rd(8'h40 + 8'(4 * w), 32'h0006000a);
		for (int n = 0; n < 4; n++)
			rd(oa(n, 1), 32'h0006000a);
		rd(oa(3, 0), 32'h00000100);
		rd(8'h08, 32'h0);
		rd(8'h42, 32'h0);
		$display("test reset done");
		// Out0: col0 +w0 -w1, col1 +w3; switch_output_one negated +w0; out2 sum; out3 depth 3
		wr(oa(0, 0), 32'h00000101);
		wr(oa(0, 2), 32'h00020001);
		wr(oa(0, 3), 32'h00000008);
		wr(oa(1, 0), 32'h00000103);
		wr(oa(1, 2), 32'h00000001);
		wr(oa(2, 0), 32'h00000105);
		wr(oa(2, 2), 32'h0010000c);
		wr(oa(2, 3), 32'h00000020);
		wr(oa(3, 0), 32'h00000301);
		wr(oa(3, 2), 32'h00000040);
		rd(oa(0, 2), 32'h00020001);
		u_hwo_proc_model.hs[0] = 9'h014;
		go(4'b0001);
		u_hwo_proc_model.hs[1] = 9'h014;
		go(4'b0000);
		u_hwo_proc_model.hs[0] = 9'h000;
		u_hwo_proc_model.hs[1] = 9'h000;
		u_hwo_proc_model.hs[3] = 9'h014;
		go(4'b0111);
		$display("test logical done");
		// Sum of w2 and w3 only: w4 is minus, w5 sits in column two
		u_hwo_proc_model.hs[3] = 9'h008;
		u_hwo_proc_model.hs[4] = 9'h064;
		u_hwo_proc_model.hs[5] = 9'h064;
		go(4'b0111);
		u_hwo_proc_model.hs[3] = 9'h006;
		go(4'b0010);
		u_hwo_proc_model.hs[2] = 9'h004;
		u_hwo_proc_model.hs[3] = 9'h005;
		go(4'b0010);
		u_hwo_proc_model.hs[2] = 9'h005;
		go(4'b0110);
		$display("test sum done");
		// Depth 3 on out3: two equal results are not enough
		u_hwo_proc_model.hs[6] = 9'h014;
		for (int k = 0; k < 3; k++)
			go(k == 2 ? 4'b1110 : 4'b0110);
		u_hwo_proc_model.hs[6] = 9'h000;
		go(4'b1110);
		// Single shot: triggers without a request change nothing
		wr(8'h00, 32'h00000002);
		u_hwo_proc_model.hs[0] = 9'h014;
		go(4'b1110);
		wr(8'h00, 32'h00000006);
		rd(8'h00, 32'h00000006);
		go(4'b0101);
		rd(8'h00, 32'h00000002);
		u_hwo_proc_model.hs[0] = 9'h000;
		go(4'b0101);
		rd(8'h04, 32'h00310005);
		// An inactive output reads 0 although its state stays 1
		wr(oa(0, 0), 32'h00000100);
		rd(8'h04, 32'h00310004);
		wr(8'h00, 32'h00000000);
		$display("test depth and single shot done");
		// Task selection
		wr(8'h00, 32'h00000500);
		tsel(3'h6, 4'hc, 1'b0, 4'h5);
		wr(8'h00, 32'h00000501);
		rd(8'h00, 32'h00000501);
		for (int s = 0; s < 8; s++)
			tsel(3'(s), 4'hc, 1'b0, {1'b0, 3'(s)});
		tsel(3'h2, 4'hf, 1'b1, 4'hf);
		tsel(3'h2, 4'h9, 1'b1, 4'h9);
		$display("test task select done");
		// Store and factory restore
		wr(8'h40, 32'h00200030);
		wr(8'h00, 32'h00000008);
		#1;
		chk("commit", {31'h0, o_commit}, 32'h1);
		wr(8'h00, 32'h00000010);
		#1;
		chk("factory", {31'h0, o_factory}, 32'h1);
		rd(8'h40, 32'h0006000a);
		rd(oa(2, 0), 32'h00000100);
		chk("outputs", {28'h0, o_switch_outputs}, 32'h0);
		$display("test store and restore done");
		test_done();
	end
endmodule
